// ===== include/uef_pkg.sv
// Package: constants, register map and carriers of the USB error flag block
`default_nettype none

package uef_pkg;

  // Clock and bus timing
  localparam int CLK_HZ     = 50_000_000;
  localparam int BUS_BIT_HZ = 12_000_000;
  localparam int TURN_BITS  = 16;
  // A least time: rounded up to whole cycles
  localparam int TURN_CYCLES =
    (TURN_BITS * CLK_HZ + BUS_BIT_HZ - 1) / BUS_BIT_HZ;
  localparam int TURN_W = 7;
  localparam logic [TURN_W-1:0] TURN_LAST = TURN_W'(TURN_CYCLES - 1);

  // Register byte offsets on the APB
  localparam int APB_ADDR_W = 8;
  localparam logic [APB_ADDR_W-1:0] OFF_FLAGS    = 8'h00;
  localparam logic [APB_ADDR_W-1:0] OFF_ENABLES  = 8'h04;
  localparam logic [APB_ADDR_W-1:0] OFF_TOP_STAT = 8'h08;
  localparam logic [APB_ADDR_W-1:0] OFF_TOP_EN   = 8'h0C;
  localparam logic [APB_ADDR_W-1:0] OFF_EVT_STAT = 8'h10;
  localparam logic [APB_ADDR_W-1:0] OFF_EVT_MASK = 8'h14;

  // Field positions in the flag, enable, event and mask registers
  localparam int BIT_STUFF  = 7;
  localparam int BIT_TURN   = 4;
  localparam int BIT_DFIELD = 3;
  localparam int BIT_CRC16  = 2;
  localparam int BIT_CRC5   = 1;
  localparam int BIT_PID    = 0;
  // Field position of the combined flag and its enable
  localparam int BIT_TOP_ERR = 1;

  // Implemented bits; 6 and 5 always read zero
  localparam logic [7:0] ERR_IMPL_MASK = 8'h9F;

  // Reset values
  localparam logic [7:0] FLAGS_RST    = 8'h00;
  localparam logic [7:0] ENABLES_RST  = 8'h00;
  localparam logic       TOP_EN_RST   = 1'b0;
  localparam logic [7:0] EVT_RST      = 8'h00;
  localparam logic [7:0] EVT_MASK_RST = 8'h00;

  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata;
  } uef_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } uef_apb_rsp_s;

  // One-cycle strobes from the serial interface engine
  typedef struct packed {
    logic stuff_err;
    logic dfield_err;
    logic crc16_err;
    logic crc5_err;
    logic pid_err;
    logic turn_arm;
    logic resp_start;
  } uef_sie_s;

  typedef enum logic [2:0] {
    REG_FLAGS, REG_ENABLES, REG_TOP_STAT, REG_TOP_EN,
    REG_EVT_STAT, REG_EVT_MASK, REG_NONE
  } uef_reg_e;

  typedef enum logic {TURN_IDLE, TURN_WAIT} uef_turn_e;

  typedef struct packed {
    uef_turn_e         mode;
    logic [TURN_W-1:0] cnt;
  } uef_turn_s;

endpackage : uef_pkg

`default_nettype wire

// ===== core/uef_turn_timer.sv
// Bus turnaround time-out timer for the USB error flag block
`default_nettype none

module uef_turn_timer import uef_pkg::*; (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic arm_i,
  input  wire logic resp_i,
  output logic      timeout_o
);

  uef_turn_s st;
  uef_turn_s next_st;

  always_comb begin
    next_st   = st;
    timeout_o = 1'b0;
    unique case (st.mode)
      TURN_IDLE: begin
        if (arm_i) begin
          next_st.mode = TURN_WAIT;
          next_st.cnt  = '0;
        end
      end
      TURN_WAIT: begin
        // A fresh end-of-packet restarts the idle count
        if (arm_i) begin
          next_st.cnt = '0;
        end else if (resp_i) begin
          next_st.mode = TURN_IDLE;
        end else if (st.cnt == TURN_LAST) begin
          timeout_o    = 1'b1;
          next_st.mode = TURN_IDLE;
        end else begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st <= '{mode: TURN_IDLE, cnt: '0};
    end else begin
      st <= next_st;
    end
  end

endmodule : uef_turn_timer

`default_nettype wire

// ===== core/uef_error_flags.sv
// USB error flag logic: latched error flags, enables, combined flag, APB
`default_nettype none


module uef_error_flags import uef_pkg::*; (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire uef_apb_req_s apb_i,
  output uef_apb_rsp_s      apb_o,
  input  wire uef_sie_s     sie_i,
  output logic              token_reject_o,
  output logic              combined_error_flag_o,
  output logic              irq_o
);

  typedef struct packed {
    logic [7:0]   usb_error_flags;
    logic [7:0]   usb_error_enables;
    logic         combined_error_enable;
    logic         top_flag;
    logic [7:0]   evt;
    logic [7:0]   evt_mask;
    logic         reject;
    logic         irq;
    uef_apb_rsp_s rsp;
  } uef_state_s;

  uef_state_s st;
  uef_state_s next_st;

  logic       turn_timeout;
  logic [7:0] err_set;
  logic       apb_setup;
  logic       apb_done;
  uef_reg_e   setup_sel;
  uef_reg_e   done_sel;

  function automatic uef_reg_e reg_decode(
    input logic [APB_ADDR_W-1:0] addr
  );
    uef_reg_e sel;
    unique case (addr)
      OFF_FLAGS:    sel = REG_FLAGS;
      OFF_ENABLES:  sel = REG_ENABLES;
      OFF_TOP_STAT: sel = REG_TOP_STAT;
      OFF_TOP_EN:   sel = REG_TOP_EN;
      OFF_EVT_STAT: sel = REG_EVT_STAT;
      OFF_EVT_MASK: sel = REG_EVT_MASK;
      default:      sel = REG_NONE;
    endcase
    return sel;
  endfunction : reg_decode

  uef_turn_timer u_turn_timer (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .arm_i     (sie_i.turn_arm),
    .resp_i    (sie_i.resp_start),
    .timeout_o (turn_timeout)
  );

  // Detection strobes placed at their flag positions
  always_comb begin
    err_set             = 8'h00;
    err_set[BIT_STUFF]  = sie_i.stuff_err;
    err_set[BIT_TURN]   = turn_timeout;
    err_set[BIT_DFIELD] = sie_i.dfield_err;
    err_set[BIT_CRC16]  = sie_i.crc16_err;
    err_set[BIT_CRC5]   = sie_i.crc5_err;
    err_set[BIT_PID]    = sie_i.pid_err;
  end

  assign apb_setup = apb_i.psel && !apb_i.penable;
  assign apb_done  = apb_i.psel && apb_i.penable && st.rsp.pready;
  assign setup_sel = reg_decode(apb_i.paddr);
  assign done_sel  = reg_decode(apb_i.paddr);

  always_comb begin
    next_st = st;
    next_st.rsp = '0;

    // Setup phase: the answer is prepared so the access completes at once
    if (apb_setup) begin
      next_st.rsp.pready = 1'b1;
      unique case (setup_sel)
        REG_FLAGS:    next_st.rsp.prdata[7:0] = st.usb_error_flags;
        REG_ENABLES:  next_st.rsp.prdata[7:0] = st.usb_error_enables;
        REG_TOP_STAT: next_st.rsp.prdata[BIT_TOP_ERR] = st.top_flag;
        REG_TOP_EN:
          next_st.rsp.prdata[BIT_TOP_ERR] = st.combined_error_enable;
        REG_EVT_STAT: next_st.rsp.prdata[7:0] = st.evt;
        REG_EVT_MASK: next_st.rsp.prdata[7:0] = st.evt_mask;
        REG_NONE:     next_st.rsp.pslverr = 1'b1;
      endcase
    end

    // Access completion: writes land and read-clear acts on this edge only
    if (apb_done && apb_i.pwrite) begin
      unique case (done_sel)
        REG_FLAGS: begin
          // Zero clears, one keeps: software cannot fake an error
          next_st.usb_error_flags =
            st.usb_error_flags & apb_i.pwdata[7:0];
        end
        REG_ENABLES: begin
          next_st.usb_error_enables =
            apb_i.pwdata[7:0] & ERR_IMPL_MASK;
        end
        REG_TOP_EN: begin
          next_st.combined_error_enable = apb_i.pwdata[BIT_TOP_ERR];
        end
        REG_EVT_MASK: begin
          next_st.evt_mask = apb_i.pwdata[7:0] & ERR_IMPL_MASK;
        end
        // Top status is read-only, writes are dropped
        REG_TOP_STAT: ;
        REG_EVT_STAT: ;
        REG_NONE: ;
      endcase
    end

    // Only bits that were reported are cleared, so a late event survives
    if (apb_done && !apb_i.pwrite && done_sel == REG_EVT_STAT) begin
      next_st.evt = st.evt & ~st.rsp.prdata[7:0];
    end

    // Detection sets regardless of enables and beats any clear
    next_st.usb_error_flags =
      (next_st.usb_error_flags | err_set) & ERR_IMPL_MASK;
    next_st.evt = (next_st.evt | err_set) & ERR_IMPL_MASK;

    next_st.reject = sie_i.crc5_err;

    // Combined flag follows the registered flags and enables
    next_st.top_flag =
      |(next_st.usb_error_flags & next_st.usb_error_enables);

    next_st.irq =
      (next_st.top_flag && next_st.combined_error_enable) ||
      |(next_st.evt & next_st.evt_mask);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st.usb_error_flags       <= FLAGS_RST;
      st.usb_error_enables     <= ENABLES_RST;
      st.combined_error_enable <= TOP_EN_RST;
      st.top_flag              <= 1'b0;
      st.evt                   <= EVT_RST;
      st.evt_mask              <= EVT_MASK_RST;
      st.reject                <= 1'b0;
      st.irq                   <= 1'b0;
      st.rsp                   <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign apb_o                 = st.rsp;
  assign token_reject_o        = st.reject;
  assign combined_error_flag_o = st.top_flag;
  assign irq_o                 = st.irq;

  // Checks on the design's own behaviour
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  logic wr_flags;
  assign wr_flags = apb_done && apb_i.pwrite && done_sel == REG_FLAGS;

  property p_stuff_latch;
    sie_i.stuff_err |=> st.usb_error_flags[BIT_STUFF];
  endproperty
  a_stuff_latch: assert property (p_stuff_latch)
    else $error("stuffing violation flag not set");

  property p_turn_latch;
    sie_i.turn_arm ##1 (!sie_i.turn_arm && !sie_i.resp_start) [*8]
      |-> !st.usb_error_flags[BIT_TURN] ||
          $past(st.usb_error_flags[BIT_TURN], 8);
  endproperty
  a_turn_latch: assert property (p_turn_latch)
    else $error("turnaround flag set before the idle limit");

  property p_turn_set;
    turn_timeout |=> st.usb_error_flags[BIT_TURN];
  endproperty
  a_turn_set: assert property (p_turn_set)
    else $error("turnaround time-out flag not set");

  property p_dfield_latch;
    sie_i.dfield_err |=> st.usb_error_flags[BIT_DFIELD];
  endproperty
  a_dfield_latch: assert property (p_dfield_latch)
    else $error("partial byte flag not set");

  property p_crc16_latch;
    sie_i.crc16_err |=> st.usb_error_flags[BIT_CRC16];
  endproperty
  a_crc16_latch: assert property (p_crc16_latch)
    else $error("data crc flag not set");

  property p_crc5_reject;
    sie_i.crc5_err |=> st.usb_error_flags[BIT_CRC5] && token_reject_o
      ##1 (!token_reject_o || $past(sie_i.crc5_err));
  endproperty
  a_crc5_reject: assert property (p_crc5_reject)
    else $error("token crc failure not recorded");

  property p_pid_ungated;
    sie_i.pid_err && !st.usb_error_enables[BIT_PID]
      |=> st.usb_error_flags[BIT_PID];
  endproperty
  a_pid_ungated: assert property (p_pid_ungated)
    else $error("packet id flag blocked by its enable");

  property p_flag_hold;
    !wr_flags |=> (st.usb_error_flags & $past(st.usb_error_flags))
      == $past(st.usb_error_flags);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("error flag dropped without a clearing write");

  property p_unimpl_zero;
    st.usb_error_flags[6:5] == 2'b00 && st.usb_error_enables[6:5] == 2'b00;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented bits not zero");

  property p_combined;
    combined_error_flag_o ==
      |(st.usb_error_flags & st.usb_error_enables);
  endproperty
  a_combined: assert property (p_combined)
    else $error("combined flag does not match enabled flags");

  property p_top_gate;
    combined_error_flag_o && st.combined_error_enable |-> irq_o;
  endproperty
  a_top_gate: assert property (p_top_gate)
    else $error("enabled combined flag does not raise the interrupt");

  property p_set_wins;
    wr_flags && apb_i.pwdata[BIT_PID] == 1'b0 && sie_i.pid_err
      |=> st.usb_error_flags[BIT_PID];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear won over a same-cycle detection");

  property p_write_one;
    wr_flags && err_set == 8'h00
      |=> st.usb_error_flags ==
          ($past(st.usb_error_flags) & $past(apb_i.pwdata[7:0]));
  endproperty
  a_write_one: assert property (p_write_one)
    else $error("flag write did not act as clear-on-zero");

  // A flag may only rise on its own detection, never from a bus write
  property p_stuff_only;
    !sie_i.stuff_err |=> !$rose(st.usb_error_flags[BIT_STUFF]);
  endproperty
  a_stuff_only: assert property (p_stuff_only)
    else $error("stuffing violation flag set with no strobe");

  property p_turn_only;
    !turn_timeout |=> !$rose(st.usb_error_flags[BIT_TURN]);
  endproperty
  a_turn_only: assert property (p_turn_only)
    else $error("turnaround flag set with no time-out");

  property p_dfield_only;
    !sie_i.dfield_err |=> !$rose(st.usb_error_flags[BIT_DFIELD]);
  endproperty
  a_dfield_only: assert property (p_dfield_only)
    else $error("partial byte flag set with no strobe");

  property p_crc16_only;
    !sie_i.crc16_err |=> !$rose(st.usb_error_flags[BIT_CRC16]);
  endproperty
  a_crc16_only: assert property (p_crc16_only)
    else $error("data crc flag set with no strobe");

  property p_crc5_only;
    !sie_i.crc5_err |=> !$rose(st.usb_error_flags[BIT_CRC5]);
  endproperty
  a_crc5_only: assert property (p_crc5_only)
    else $error("token crc flag set with no strobe");

  property p_pid_only;
    !sie_i.pid_err |=> !$rose(st.usb_error_flags[BIT_PID]);
  endproperty
  a_pid_only: assert property (p_pid_only)
    else $error("packet id flag set with no strobe");

  property p_reject_only;
    !sie_i.crc5_err |=> !token_reject_o;
  endproperty
  a_reject_only: assert property (p_reject_only)
    else $error("token rejected with no crc failure");

  // Register side: writes that must or must not move state, and interrupt gating
  property p_flags_clear;
    wr_flags && apb_i.pwdata[7:0] == 8'h00 && err_set == 8'h00
      |=> st.usb_error_flags == 8'h00;
  endproperty
  a_flags_clear: assert property (p_flags_clear)
    else $error("zero write did not clear the flags");

  property p_top_read_only;
    apb_done && apb_i.pwrite && done_sel == REG_TOP_STAT && err_set == 8'h00
      |=> $stable(combined_error_flag_o);
  endproperty
  a_top_read_only: assert property (p_top_read_only)
    else $error("write to top status moved the combined flag");

  property p_enable_write;
    apb_done && apb_i.pwrite && done_sel == REG_ENABLES
      |=> st.usb_error_enables ==
          ($past(apb_i.pwdata[7:0]) & ERR_IMPL_MASK);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable write did not land");

  property p_irq_quiet;
    !st.combined_error_enable && st.evt_mask == 8'h00 |-> !irq_o;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt raised with every source gated");

endmodule : uef_error_flags

`default_nettype wire

// ===== verification/uef_sie_model.sv
// Serial engine stand-in that strobes error and turnaround events
`default_nettype none

module uef_sie_model import uef_pkg::*; (
  input  wire logic clk_sys_i,
  output uef_sie_s  sie_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial sie_o = '0;

  // One strobe cycle; several fields may be set together
  task automatic pulse(input logic [6:0] v);
    @(posedge clk_sys_i);
    sie_o <= v;
    @(posedge clk_sys_i);
    sie_o <= '0;
  endtask : pulse

  // Host answers gap cycles after the packet end; zero means it stays silent
  task automatic turn(input int gap);
    pulse(7'h02);
    if (gap > 0) begin
      repeat (gap - 1) @(posedge clk_sys_i);
      pulse(7'h01);
    end
  endtask : turn
endmodule : uef_sie_model

`default_nettype wire

// ===== verification/usb_error_flag_logic_tb_top.sv
// Testbench for the USB error flag block
`default_nettype none
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin \
  n_errors++; $display("[FAIL] %s exp %h got %h", nm, e, s); end end

module usb_error_flag_logic_tb_top import uef_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic         clk_sys_i = 1'b0;
  logic         rst_i;
  uef_apb_req_s req;
  uef_apb_rsp_s rsp;
  uef_sie_s     sie;
  logic         tok;
  logic         comb;
  logic         irq;
  logic [31:0]  rd_q;
  logic         err_q;
  int           n_errors = 0;
  int           compares = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  uef_sie_model m (.clk_sys_i(clk_sys_i), .sie_o(sie));

  uef_error_flags dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .apb_i(req),
    .apb_o(rsp), .sie_i(sie), .token_reject_o(tok),
    .combined_error_flag_o(comb), .irq_o(irq));

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys_i);
    req.penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_sys_i);
    end while (rsp.pready !== 1'b1);
    rd_q = rsp.prdata;
    err_q = rsp.pslverr;
    req <= '0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [7:0] e, string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, {24'h0, e}, rd_q)
  endtask : rd

  task automatic w2();
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask : w2

  task automatic t_reset();
    logic [7:0] offs [6] = '{OFF_FLAGS, OFF_ENABLES, OFF_TOP_STAT,
                             OFF_TOP_EN, OFF_EVT_STAT, OFF_EVT_MASK};
    foreach (offs[i]) rd(offs[i], 8'h00, "reset value");
    rd(8'h18, 8'h00, "unmapped data");
    `CHK("unmapped err", 1'b1, err_q)
  endtask : t_reset

  task automatic t_flags();
    int pos [5] = '{BIT_STUFF, BIT_DFIELD, BIT_CRC16, BIT_CRC5, BIT_PID};
    for (int i = 0; i < 5; i++) begin
      m.pulse(7'h40 >> i);
      #1;
      `CHK("reject", i == 3, tok)
      `CHK("comb off", 1'b0, comb)
      rd(OFF_FLAGS, 8'h01 << pos[i], "flag bit");
      apb(1'b1, OFF_FLAGS, 32'h0);
    end
  endtask : t_flags

  task automatic t_gate();
    m.pulse(7'h04);
    apb(1'b1, OFF_FLAGS, 32'hFF);
    rd(OFF_FLAGS, 8'h01, "write one keeps");
    apb(1'b1, OFF_ENABLES, 32'hFF);
    rd(OFF_ENABLES, 8'h9F, "enables");
    apb(1'b1, OFF_TOP_EN, 32'h2);
    w2();
    `CHK("comb on", 1'b1, comb)
    `CHK("irq on", 1'b1, irq)
    apb(1'b1, OFF_TOP_STAT, 32'h0);
    rd(OFF_TOP_STAT, 8'h02, "top kept");
    apb(1'b1, OFF_ENABLES, 32'h9E);
    w2();
    `CHK("comb gated", 1'b0, comb)
    apb(1'b1, OFF_TOP_STAT, 32'hFF);
    rd(OFF_TOP_STAT, 8'h00, "top not set");
    apb(1'b1, OFF_ENABLES, 32'h01);
    apb(1'b1, OFF_TOP_EN, 32'h0);
    w2();
    `CHK("irq gated", 1'b0, irq)
    `CHK("comb again", 1'b1, comb)
    apb(1'b1, OFF_FLAGS, 32'h0);
    w2();
    `CHK("comb cleared", 1'b0, comb)
  endtask : t_gate

  task automatic t_same();
    m.pulse(7'h04);
    fork
      apb(1'b1, OFF_FLAGS, 32'h0);
      begin
        @(posedge clk_sys_i);
        m.pulse(7'h04);
      end
    join
    rd(OFF_FLAGS, 8'h01, "detect wins");
    apb(1'b1, OFF_FLAGS, 32'h0);
  endtask : t_same

  // All error strobes at once, then writes with the upper bits set
  task automatic t_multi();
    m.pulse(7'h7C);
    #1;
    `CHK("reject multi", 1'b1, tok)
    rd(OFF_FLAGS, 8'h8F, "all flags");
    apb(1'b1, OFF_FLAGS, 32'hFFFF_FF7E);
    rd(OFF_FLAGS, 8'h0E, "clear by zero");
    apb(1'b1, OFF_FLAGS, 32'hFFFF_FF00);
    rd(OFF_FLAGS, 8'h00, "upper bits ignored");
  endtask : t_multi

  task automatic t_turn();
    apb(1'b1, OFF_ENABLES, 32'h10);
    m.turn(0);
    repeat (TURN_CYCLES - 1) @(posedge clk_sys_i);
    #1;
    `CHK("turn early", 1'b0, comb)
    @(posedge clk_sys_i);
    #1;
    `CHK("turn due", 1'b1, comb)
    rd(OFF_FLAGS, 8'h10, "turn flag");
    apb(1'b1, OFF_FLAGS, 32'h0);
    m.turn(30);
    repeat (80) @(posedge clk_sys_i);
    rd(OFF_FLAGS, 8'h00, "answered");
  endtask : t_turn

  task automatic t_irq();
    rd(OFF_EVT_STAT, 8'h9F, "events all");
    apb(1'b1, OFF_EVT_MASK, 32'h01);
    m.pulse(7'h08);
    w2();
    `CHK("irq masked", 1'b0, irq)
    m.pulse(7'h04);
    w2();
    `CHK("irq event", 1'b1, irq)
    rd(OFF_EVT_STAT, 8'h03, "events");
    w2();
    `CHK("irq cleared", 1'b0, irq)
    rd(OFF_EVT_STAT, 8'h00, "events cleared");
  endtask : t_irq

  task automatic results();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  // Whole run needs about 400 cycles
  initial begin
    repeat (6000) @(posedge clk_sys_i);
    n_errors++;
    results();
  end

  initial begin
    rst_i = 1'b1;
    req = '0;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset();
    t_flags();
    t_gate();
    t_same();
    t_multi();
    t_turn();
    t_irq();
    // Second reset in mid-run must wipe flags, enables and the event mask
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset();
    results();
  end
endmodule : usb_error_flag_logic_tb_top

`default_nettype wire
